// >>> hdl/scif_pkg.sv
package scif_pkg;
   // ==========================================
   // pin sampling
   localparam int NPIN = 14;
   localparam int P_CS = 0;
   localparam int P_CMD = 1;
   localparam int P_RSTQ = 2;
   localparam int P_CV = 3;
   localparam int P_CSEL = 4;
   localparam int P_DIVA = 5;
   localparam int P_DIVB = 6;
   localparam int P_STB = 7;
   localparam int P_MODE = 8;
   localparam int P_CARD_PRESENT_N = 9;
   localparam int P_UP = 10;
   localparam int P_LOW = 11;
   localparam int P_OC = 12;
   localparam int P_OH = 13;
   // control inputs held by chip select, pins P_CMD..P_MODE
   localparam int NCTL = 8;
   localparam logic [NPIN-1:0] PIN_RST = 14'h0b03;
   // ==========================================
   // timing
   localparam int CLK_HZ = 10000000;
   localparam int CLK_NS = 100;
   localparam int TD_MIN_NS = 50;
   localparam int TD_MAX_NS = 400;
   localparam int TD_CYC = (TD_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int ALARM_MS = 10;
   localparam int ALARM_CYC = ALARM_MS * (CLK_HZ / 1000);
   localparam int SLOW_OSC_HZ = 32000;
   localparam int SLOW_HALF_CYC = CLK_HZ / SLOW_OSC_HZ;
   localparam logic [8:0] SLOW_LAST = 9'(SLOW_HALF_CYC - 1);
   localparam logic [6:0] WAKE_CLKS = 7'h60;
   localparam int HALF_T_CYC = 64;
   localparam logic [6:0] HALF_T_LAST = 7'(HALF_T_CYC - 1);
   // ==========================================
   // sequencer steps in half units of T
   localparam logic [3:0] ACT_VCC = 4'h3;
   localparam logic [3:0] ACT_LINES = 4'h8;
   localparam logic [3:0] ACT_RST = 4'he;
   localparam logic [3:0] DEA_CLK = 4'h1;
   localparam logic [3:0] DEA_LINES = 4'h2;
   localparam logic [3:0] DEA_VCC = 4'h3;
   localparam logic [3:0] DEA_END = 4'ha;
   // ==========================================
   // operating modes
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SLEEP = 6'h02,
      ST_WAKE = 6'h04,
      ST_ACT = 6'h08,
      ST_ON = 6'h10,
      ST_DEACT = 6'h20
   } scif_st_t;
endpackage : scif_pkg

// >>> hdl/scif_relay.sv
`timescale 1ns/100ps
`default_nettype none
module scif_relay (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic a_in,
   input wire logic b_in,
   input wire logic a_en,
   input wire logic b_en,
   output logic a_out,
   output logic a_oe,
   output logic b_out,
   output logic b_oe
);
   typedef enum logic [5:0] {
      RL_IDLE = 6'h01,
      RL_AM = 6'h02,
      RL_BM = 6'h04,
      RL_ABST = 6'h08,
      RL_BBST = 6'h10,
      RL_CONF = 6'h20
   } scif_rl_t;
   localparam int TD_CYC = scif_pkg::TD_CYC;
   // ==========================================
   // sampling
   logic [1:0] s1_r, s2_r, s3_r, lv_r, pv_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 2'h3;
         s2_r <= 2'h3;
         s3_r <= 2'h3;
         lv_r <= 2'h3;
         pv_r <= 2'h3;
      end else begin
         s1_r <= {b_in, a_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         lv_r <= (s2_r & s3_r) | (lv_r & (s2_r ^ s3_r));
         pv_r <= lv_r;
      end
   end
   logic fall_a, fall_b, live;
   assign fall_a = pv_r[0] & ~lv_r[0];
   assign fall_b = pv_r[1] & ~lv_r[1];
   assign live = a_en & b_en;
   // ==========================================
   // direction
   scif_rl_t st_r, st_nxt;
   logic [3:0] bst_r;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         RL_IDLE: begin
            if (fall_a && fall_b) st_nxt = RL_CONF; // R15
            else if (fall_a) st_nxt = RL_AM; // R12
            else if (fall_b) st_nxt = RL_BM; // R12
         end
         RL_AM: if (lv_r[0]) st_nxt = RL_ABST; // R14
         RL_BM: if (lv_r[1]) st_nxt = RL_BBST; // R14
         RL_ABST: if (bst_r == 4'(TD_CYC - 1)) st_nxt = RL_IDLE; // R14
         RL_BBST: if (bst_r == 4'(TD_CYC - 1)) st_nxt = RL_IDLE; // R14
         RL_CONF: if (lv_r == 2'h3) st_nxt = RL_IDLE; // R15
         default: st_nxt = RL_IDLE;
      endcase
      if (!live) st_nxt = RL_IDLE;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= RL_IDLE;
         bst_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         bst_r <= (st_nxt == st_r) ? bst_r + 4'h1 : 4'h0;
      end
   end
   // ==========================================
   // line drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_out <= 1'b0;
         a_oe <= 1'b0;
         b_out <= 1'b0;
         b_oe <= 1'b1;
      end else begin
         a_oe <= a_en & ((st_nxt == RL_BM) | (st_nxt == RL_BBST)); // R13
         a_out <= st_nxt == RL_BBST; // R14
         b_oe <= ~b_en | (st_nxt == RL_AM) | (st_nxt == RL_ABST); // R13
         b_out <= b_en & (st_nxt == RL_ABST); // R14
      end
   end
endmodule : scif_relay
`default_nettype wire

// >>> hdl/scif_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: sequencer waits for supply; low supply deactivates
// R2: select high: inputs govern, lines mirror, fault driven
// R3: select low: inputs held, lines cut, fault floats
// R4: retriggerable alarm pulse at least 10 ms
// R5: alarm delay from upper crossing; drop reasserts
// R6: strobe clocks card when source select high
// R7: rc ratio gives half internal on both clocks
// R8: crystal ratios: /4, /2, stop; host gets crystal
// R9: sleep stops card clock; host clock slowed
// R10: host keeps strobe stable during activation
// R11: host keeps clock source fixed during activation
// R12: first falling side becomes master, other blocked
// R13: master low reaches slave within transfer delay
// R14: slave driven high one delay, then idle
// R15: conflict lines released once both sides high
// R16: line toggling stays at or below 200 kHz
// R17: reset gives idle, contacts off, host lines floating
// R18: mode low means sleep, no activation
// R19: active session deactivates fully before sleeping
// R20: wake waits 96 slow host clocks
// R21: sleep keeps supervisor, alarm, presence, fault alive
// R22: power request low starts activation from idle
// R23: lines low until 4T; reset follows from 7T
// R24: deactivation counts down reset, clock, lines, supply
// R25: fault pulls interrupt low, released per card presence
// R26: T from clock count; inputs synchronised
module scif_ctrl #(
   parameter int ALARM_CYC = scif_pkg::ALARM_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic unit_select,
   input wire logic card_power_request_n,
   input wire logic card_reset_request,
   input wire logic card_voltage_select,
   input wire logic card_clock_source_sel,
   input wire logic clock_ratio_sel_a,
   input wire logic clock_ratio_sel_b,
   input wire logic strobe_in,
   input wire logic mode_in,
   input wire logic card_present_n,
   input wire logic supply_above_upper,
   input wire logic supply_below_lower,
   input wire logic overcurrent_in,
   input wire logic overheat_in,
   input wire logic host_data_line_in,
   output logic host_data_line_out,
   output logic host_data_line_oe,
   input wire logic host_aux_line_a_in,
   output logic host_aux_line_a_out,
   output logic host_aux_line_a_oe,
   input wire logic host_aux_line_b_in,
   output logic host_aux_line_b_out,
   output logic host_aux_line_b_oe,
   input wire logic card_data_line_in,
   output logic card_data_line_out,
   output logic card_data_line_oe,
   input wire logic card_aux_line_a_in,
   output logic card_aux_line_a_out,
   output logic card_aux_line_a_oe,
   input wire logic card_aux_line_b_in,
   output logic card_aux_line_b_out,
   output logic card_aux_line_b_oe,
   output logic host_clock_out,
   output logic card_clock_out,
   output logic card_reset_out,
   output logic card_supply_on,
   output logic card_voltage_high,
   output logic converter_on,
   output logic alarm_out,
   output logic fault_irq_out,
   output logic fault_irq_oe
);
   localparam int ALW = $clog2(ALARM_CYC + 1);
   // ==========================================
   // pin sampling, change taken when stages agree
   logic [scif_pkg::NPIN-1:0] raw, s1_r, s2_r, s3_r, pin_r;
   assign raw = {overheat_in, overcurrent_in, supply_below_lower,
      supply_above_upper, card_present_n, mode_in, strobe_in,
      clock_ratio_sel_b, clock_ratio_sel_a, card_clock_source_sel,
      card_voltage_select, card_reset_request, card_power_request_n,
      unit_select};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= scif_pkg::PIN_RST;
         s2_r <= scif_pkg::PIN_RST;
         s3_r <= scif_pkg::PIN_RST;
         pin_r <= scif_pkg::PIN_RST;
      end else begin
         s1_r <= raw; // R26
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r)); // R26
      end
   end
   logic cs;
   assign cs = pin_r[scif_pkg::P_CS];
   // ==========================================
   // control inputs held while deselected
   logic [scif_pkg::NCTL-1:0] ctl_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= scif_pkg::PIN_RST[scif_pkg::P_MODE:scif_pkg::P_CMD];
      end else if (cs) begin
         ctl_r <= pin_r[scif_pkg::P_MODE:scif_pkg::P_CMD]; // R2 R3
      end
   end
   logic cmd_n, rst_req, cv_sel, clk_src, div_a, div_b, stb, mode;
   assign cmd_n = ctl_r[scif_pkg::P_CMD-1];
   assign rst_req = ctl_r[scif_pkg::P_RSTQ-1];
   assign cv_sel = ctl_r[scif_pkg::P_CV-1];
   assign clk_src = ctl_r[scif_pkg::P_CSEL-1];
   assign div_a = ctl_r[scif_pkg::P_DIVA-1];
   assign div_b = ctl_r[scif_pkg::P_DIVB-1];
   assign stb = ctl_r[scif_pkg::P_STB-1];
   assign mode = ctl_r[scif_pkg::P_MODE-1];
   logic card_present_n_n, up, low, oc, oh;
   assign card_present_n_n = pin_r[scif_pkg::P_CARD_PRESENT_N];
   assign up = pin_r[scif_pkg::P_UP];
   assign low = pin_r[scif_pkg::P_LOW];
   assign oc = pin_r[scif_pkg::P_OC];
   assign oh = pin_r[scif_pkg::P_OH];
   // ==========================================
   // supply supervisor and alarm
   logic up_d_r, supply_ok_r, alarm_load, alarm_now;
   logic [ALW-1:0] alarm_cnt_r;
   assign alarm_load = low | (up & ~up_d_r); // R4 R5
   assign alarm_now = alarm_load | (alarm_cnt_r != '0);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_d_r <= 1'b0;
         supply_ok_r <= 1'b0;
      end else begin
         up_d_r <= up;
         if (low) supply_ok_r <= 1'b0; // R1
         else if (up) supply_ok_r <= 1'b1; // R1
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_cnt_r <= ALW'(ALARM_CYC);
         alarm_out <= 1'b1;
      end else begin
         if (alarm_load) alarm_cnt_r <= ALW'(ALARM_CYC); // R4
         else if (alarm_cnt_r != '0) alarm_cnt_r <= alarm_cnt_r - 1'b1; // R5
         alarm_out <= alarm_now; // R5 R21
      end
   end
   // ==========================================
   // oscillators
   logic [2:0] div_r;
   logic [8:0] slow_cnt_r;
   logic slow_clk_r, slow_rise;
   assign slow_rise = (slow_cnt_r == scif_pkg::SLOW_LAST) & ~slow_clk_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 3'h0;
         slow_cnt_r <= 9'h000;
         slow_clk_r <= 1'b0;
      end else begin
         div_r <= div_r + 3'h1;
         if (slow_cnt_r == scif_pkg::SLOW_LAST) begin
            slow_cnt_r <= 9'h000;
            slow_clk_r <= ~slow_clk_r; // R9
         end else begin
            slow_cnt_r <= slow_cnt_r + 9'h001;
         end
      end
   end
   // ==========================================
   // mode machine
   scif_pkg::scif_st_t st_r, st_nxt;
   logic [6:0] seq_cnt_r, wake_cnt_r;
   logic [3:0] step_r;
   logic fault_r, fault_evt, deact_req, in_session;
   assign in_session = (st_r == scif_pkg::ST_ACT) | (st_r == scif_pkg::ST_ON);
   assign fault_evt = in_session & (oc | oh | card_present_n_n | low); // R25
   assign deact_req = cmd_n | ~mode | fault_evt | alarm_now | ~supply_ok_r;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         scif_pkg::ST_IDLE: begin
            if (!mode) begin
               st_nxt = scif_pkg::ST_SLEEP; // R18
            end else if (!cmd_n && supply_ok_r && !alarm_now && !fault_r) begin
               st_nxt = scif_pkg::ST_ACT; // R1 R22
            end
         end
         scif_pkg::ST_SLEEP: if (mode) st_nxt = scif_pkg::ST_WAKE;
         scif_pkg::ST_WAKE: begin
            if (!mode) st_nxt = scif_pkg::ST_SLEEP; // R18
            else if (wake_cnt_r == scif_pkg::WAKE_CLKS) st_nxt = scif_pkg::ST_IDLE; // R20
         end
         scif_pkg::ST_ACT: begin
            if (deact_req) st_nxt = scif_pkg::ST_DEACT; // R1 R24 R25
            else if (step_r == scif_pkg::ACT_RST) st_nxt = scif_pkg::ST_ON; // R23
         end
         scif_pkg::ST_ON: if (deact_req) st_nxt = scif_pkg::ST_DEACT; // R19 R24
         scif_pkg::ST_DEACT: begin
            if (step_r == scif_pkg::DEA_END) begin
               st_nxt = mode ? scif_pkg::ST_IDLE : scif_pkg::ST_SLEEP; // R19
            end
         end
         default: st_nxt = scif_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= scif_pkg::ST_IDLE; // R17
      end else begin
         st_r <= st_nxt;
      end
   end
   // ==========================================
   // sequencer time base in half units of T
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_cnt_r <= 7'h00;
         step_r <= 4'h0;
      end else if (st_nxt != st_r) begin
         seq_cnt_r <= 7'h00;
         step_r <= 4'h0;
      end else if (seq_cnt_r == scif_pkg::HALF_T_LAST) begin
         seq_cnt_r <= 7'h00; // R26
         if (step_r != 4'hf) step_r <= step_r + 4'h1;
      end else begin
         seq_cnt_r <= seq_cnt_r + 7'h01;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_r <= 7'h00;
      end else if (st_r != scif_pkg::ST_WAKE) begin
         wake_cnt_r <= 7'h00;
      end else if (slow_rise && wake_cnt_r != scif_pkg::WAKE_CLKS) begin
         wake_cnt_r <= wake_cnt_r + 7'h01; // R20
      end
   end
   // ==========================================
   // card contacts
   logic lines_en_r, clk_run_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_on <= 1'b0;
         card_supply_on <= 1'b0;
         lines_en_r <= 1'b0;
         clk_run_r <= 1'b0;
         card_reset_out <= 1'b0;
         card_voltage_high <= 1'b0;
      end else begin
         case (st_r)
            scif_pkg::ST_ACT: begin
               converter_on <= 1'b1;
               card_supply_on <= step_r >= scif_pkg::ACT_VCC;
               lines_en_r <= step_r >= scif_pkg::ACT_LINES; // R23
               if (step_r >= scif_pkg::ACT_LINES && rst_req) clk_run_r <= 1'b1; // R23
               card_reset_out <= 1'b0;
            end
            scif_pkg::ST_ON: begin
               converter_on <= 1'b1;
               card_supply_on <= 1'b1;
               lines_en_r <= 1'b1;
               clk_run_r <= 1'b1;
               card_reset_out <= ~rst_req; // R23
            end
            scif_pkg::ST_DEACT: begin
               card_reset_out <= 1'b0; // R24
               clk_run_r <= clk_run_r & (step_r < scif_pkg::DEA_CLK); // R24
               lines_en_r <= lines_en_r & (step_r < scif_pkg::DEA_LINES); // R24
               card_supply_on <= card_supply_on & (step_r < scif_pkg::DEA_VCC); // R24
               converter_on <= step_r < scif_pkg::DEA_END; // R24
            end
            default: begin
               converter_on <= 1'b0; // R17 R21
               card_supply_on <= 1'b0;
               lines_en_r <= 1'b0;
               clk_run_r <= 1'b0;
               card_reset_out <= 1'b0;
               card_voltage_high <= cv_sel;
            end
         endcase
      end
   end
   // ==========================================
   // clock outputs
   logic card_src, sleepy;
   assign sleepy = (st_r == scif_pkg::ST_SLEEP) | (st_r == scif_pkg::ST_WAKE);
   always_comb begin
      card_src = 1'b0;
      if (clk_src) card_src = stb; // R6
      else if (div_a && !div_b) card_src = div_r[1]; // R7
      else if (!div_a && !div_b) card_src = div_r[2]; // R8
      else if (!div_a && div_b) card_src = div_r[1]; // R8
      else card_src = 1'b0; // R8
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         card_clock_out <= 1'b0;
         host_clock_out <= 1'b0;
      end else begin
         card_clock_out <= clk_run_r & ~sleepy & card_src; // R9
         if (sleepy) host_clock_out <= slow_clk_r; // R9
         else if (!clk_src && div_a && !div_b) host_clock_out <= div_r[1]; // R7
         else host_clock_out <= div_r[0]; // R8 R17
      end
   end
   // ==========================================
   // fault interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_r <= 1'b0;
         fault_irq_out <= 1'b0;
         fault_irq_oe <= 1'b0;
      end else begin
         if (fault_evt) fault_r <= 1'b1; // R25
         else if (st_r == scif_pkg::ST_IDLE && !card_present_n_n && cmd_n) fault_r <= 1'b0; // R25
         fault_irq_out <= 1'b0;
         fault_irq_oe <= (fault_r | fault_evt) & cs; // R2 R3 R21
      end
   end
   // ==========================================
   // line relays
   logic [2:0] h_in, c_in, h_out, h_oe, c_out, c_oe;
   assign h_in = {host_aux_line_b_in, host_aux_line_a_in, host_data_line_in};
   assign c_in = {card_aux_line_b_in, card_aux_line_a_in, card_data_line_in};
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_line
         scif_relay u_relay (
            .clk(clk),
            .rst_n(rst_n),
            .a_in(h_in[g]),
            .b_in(c_in[g]),
            .a_en(cs), // R2 R3
            .b_en(lines_en_r), // R23
            .a_out(h_out[g]),
            .a_oe(h_oe[g]),
            .b_out(c_out[g]),
            .b_oe(c_oe[g])
         );
      end
   endgenerate
   assign host_data_line_out = h_out[0];
   assign host_data_line_oe = h_oe[0];
   assign host_aux_line_a_out = h_out[1];
   assign host_aux_line_a_oe = h_oe[1];
   assign host_aux_line_b_out = h_out[2];
   assign host_aux_line_b_oe = h_oe[2];
   assign card_data_line_out = c_out[0];
   assign card_data_line_oe = c_oe[0];
   assign card_aux_line_a_out = c_out[1];
   assign card_aux_line_a_oe = c_oe[1];
   assign card_aux_line_b_out = c_out[2];
   assign card_aux_line_b_oe = c_oe[2];
endmodule : scif_ctrl
`default_nettype wire

// >>> sim/scif_chk.sv
`timescale 1ns/100ps
`default_nettype none
module scif_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic unit_select,
   input wire logic supply_below_lower,
   input wire logic host_data_line_in,
   input wire logic host_data_line_out,
   input wire logic host_data_line_oe,
   input wire logic card_data_line_in,
   input wire logic card_data_line_out,
   input wire logic card_data_line_oe,
   input wire logic card_clock_out,
   input wire logic card_supply_on,
   input wire logic converter_on,
   input wire logic alarm_out,
   input wire logic fault_irq_out,
   input wire logic fault_irq_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // data relay
   sequence s_idle;
      !host_data_line_oe && !card_data_line_oe && card_data_line_in && host_data_line_in;
   endsequence
   sequence s_host_low;
      s_idle ##1 (!host_data_line_in && card_data_line_in && unit_select) [*4];
   endsequence
   a_slave_follows: assert property (s_host_low |-> ##[1:2] (card_data_line_oe && !card_data_line_out))
      else $error("card line not driven low after host fall");
   a_card_boost: assert property (card_data_line_oe && card_data_line_out |=> !card_data_line_oe)
      else $error("card boost longer than one delay");
   a_host_boost: assert property (host_data_line_oe && host_data_line_out |=> !host_data_line_oe)
      else $error("host boost longer than one delay");
   a_no_clash: assert property (!(host_data_line_oe && !host_data_line_out && card_data_line_oe && !card_data_line_out))
      else $error("both sides driven low");
   a_unsel_float: assert property (!unit_select [*5] |=> !host_data_line_oe && !fault_irq_oe)
      else $error("host side driven while unselected");
   // ==========================================
   // supervisor and sequencer
   a_alarm_drop: assert property (supply_below_lower [*5] |=> alarm_out)
      else $error("alarm not raised on supply drop");
   a_alarm_inhibit: assert property (alarm_out && !converter_on |=> !converter_on)
      else $error("activation under alarm");
   a_idle_quiet: assert property (!converter_on [*2] |-> !card_supply_on && !card_clock_out)
      else $error("card contacts active outside session");
   a_supply_late: assert property ($rose(card_supply_on) |-> $past(converter_on, 150))
      else $error("card supply before converter start");
   a_irq_low: assert property (fault_irq_oe |-> !fault_irq_out)
      else $error("interrupt not pulled low");
endmodule : scif_chk
bind scif_ctrl scif_chk u_chk (.*);
`default_nettype wire

// >>> sim/scif_card_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module scif_card_mdl (
   input wire logic [2:0] dev_out,
   input wire logic [2:0] dev_oe,
   input wire logic [2:0] pull_low,
   output logic [2:0] line
);
   // ==========================================
   // pulled-up open lines
   assign line = ~pull_low & (~dev_oe | dev_out);
endmodule : scif_card_mdl
`default_nettype wire

// >>> sim/smart_card_interface_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module smart_card_interface_control_tb;
   localparam int AC = 50;
   typedef struct {logic a, b, src, stb, cl; int tc, th;} scif_row_t;
   logic clk, rst_n, unit_select, card_power_request_n, card_reset_request, card_voltage_select;
   logic card_clock_source_sel, clock_ratio_sel_a, clock_ratio_sel_b, strobe_in, mode_in;
   logic card_present_n, supply_above_upper, supply_below_lower, overcurrent_in, overheat_in;
   logic host_data_line_in, host_aux_line_a_in, host_aux_line_b_in;
   logic card_data_line_in, card_aux_line_a_in, card_aux_line_b_in;
   logic host_data_line_out, host_data_line_oe, host_aux_line_a_out, host_aux_line_a_oe;
   logic host_aux_line_b_out, host_aux_line_b_oe, card_data_line_out, card_data_line_oe;
   logic card_aux_line_a_out, card_aux_line_a_oe, card_aux_line_b_out, card_aux_line_b_oe;
   logic host_clock_out, card_clock_out, card_reset_out, card_supply_on, card_voltage_high;
   logic converter_on, alarm_out, fault_irq_out, fault_irq_oe;
   logic [2:0] h_pull, c_pull, h_line, c_line, h_out, h_oe, c_out, c_oe;
   int err_count = 0, n_checks = 0, tog_h, tog_c;
   scif_row_t rows[6] = '{'{1, 0, 0, 0, 0, 32, 32}, '{0, 0, 0, 0, 0, 16, 64},
      '{0, 1, 0, 0, 0, 32, 64}, '{1, 1, 0, 0, 0, 0, 64}, '{0, 0, 1, 0, 0, 0, 64},
      '{0, 0, 1, 1, 1, 0, 64}};
   assign h_out = {host_aux_line_b_out, host_aux_line_a_out, host_data_line_out};
   assign h_oe = {host_aux_line_b_oe, host_aux_line_a_oe, host_data_line_oe};
   assign c_out = {card_aux_line_b_out, card_aux_line_a_out, card_data_line_out};
   assign c_oe = {card_aux_line_b_oe, card_aux_line_a_oe, card_data_line_oe};
   assign h_line = ~h_pull & (~h_oe | h_out);
   assign {host_aux_line_b_in, host_aux_line_a_in, host_data_line_in} = h_line;
   assign {card_aux_line_b_in, card_aux_line_a_in, card_data_line_in} = c_line;
   scif_ctrl #(.ALARM_CYC(AC)) uut (.*);
   scif_card_mdl u_card (.dev_out(c_out), .dev_oe(c_oe), .pull_low(c_pull), .line(c_line));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ==========================================
   // helpers
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check
   task count(input int n);
      logic ph, pc;
      tog_h = 0;
      tog_c = 0;
      for (int i = 0; i < n; i++) begin
         ph = host_clock_out;
         pc = card_clock_out;
         tick(1);
         tog_h += int'(ph !== host_clock_out);
         tog_c += int'(pc !== card_clock_out);
      end
   endtask : count
   task automatic wait_conv(input logic v, input int lim);
      int k = 0;
      while (converter_on !== v && k < lim) begin
         tick(1);
         k++;
      end
      check(converter_on, v, "converter");
   endtask : wait_conv
   task results;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   initial begin
      #(95000 * 100);
      err_count++;
      results;
   end
   // ==========================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      {unit_select, card_power_request_n, mode_in, supply_below_lower} = 4'hf;
      {card_reset_request, card_voltage_select, card_clock_source_sel, strobe_in} = 4'h0;
      {clock_ratio_sel_a, clock_ratio_sel_b, card_present_n, supply_above_upper} = 4'h0;
      {overcurrent_in, overheat_in, h_pull, c_pull} = 8'h00;
      tick(6);
      check(alarm_out, 1'b1, "alarm in reset");
      check({h_oe, c_oe, c_out}, 9'h038, "lines in reset");
      rst_n = 1'b1;
      {supply_below_lower, supply_above_upper, card_power_request_n} = 3'h2;
      tick(AC);
      check({alarm_out, converter_on, card_voltage_high}, 3'h4, "held by alarm");
      wait_conv(1'b1, 20);
      tick(180);
      check(card_supply_on, 1'b0, "supply early");
      tick(220);
      check({card_supply_on, c_line}, 4'h8, "supply, lines low");
      tick(560);
      check(card_reset_out, 1'b1, "reset out");
      card_reset_request = 1'b1;
      tick(6);
      check(card_reset_out, 1'b0, "reset out");
      $display("test activation done");
      foreach (rows[i]) begin
         {clock_ratio_sel_a, clock_ratio_sel_b} = {rows[i].a, rows[i].b};
         {card_clock_source_sel, strobe_in} = {rows[i].src, rows[i].stb};
         tick(10);
         count(64);
         check(8'(tog_c), 8'(rows[i].tc), "card clock");
         check(8'(tog_h), 8'(rows[i].th), "host clock");
         if (rows[i].tc == 0) check(card_clock_out, rows[i].cl, "card level");
      end
      {card_clock_source_sel, strobe_in} = 2'h0;
      $display("test clocks done");
      for (int i = 0; i < 3; i++) begin
         h_pull[i] = 1'b1;
         tick(5);
         check(c_line[i], 1'b0, "host low relayed");
         tick(25);
         h_pull[i] = 1'b0;
         tick(30);
         check({c_line[i], c_oe[i]}, 2'h2, "card side idle");
         c_pull[i] = 1'b1;
         tick(5);
         check(h_line[i], 1'b0, "card low relayed");
         tick(25);
         c_pull[i] = 1'b0;
         tick(30);
         check(h_oe[i], 1'b0, "host side idle");
         {h_pull[i], c_pull[i]} = 2'h3;
         tick(30);
         {h_pull[i], c_pull[i]} = 2'h0;
         tick(30);
         check({h_oe[i], c_oe[i], h_line[i], c_line[i]}, 4'h3, "conflict released");
      end
      $display("test relay done");
      unit_select = 1'b0;
      tick(6);
      card_reset_request = 1'b0;
      c_pull[0] = 1'b1;
      tick(30);
      check({card_reset_out, h_oe[0], h_line[0], fault_irq_oe}, 4'h2, "unselected");
      c_pull[0] = 1'b0;
      tick(30);
      unit_select = 1'b1;
      tick(10);
      check(card_reset_out, 1'b1, "selected again");
      $display("test select done");
      card_power_request_n = 1'b1;
      tick(7);
      check(card_reset_out, 1'b0, "reset dropped");
      tick(140);
      check({card_clock_out, c_line}, 4'h0, "clock, lines off");
      wait_conv(1'b0, 700);
      check(card_supply_on, 1'b0, "supply off");
      $display("test deactivation done");
      mode_in = 1'b0;
      tick(700);
      count(624);
      check(8'(tog_h), 8'h02, "slow host clock");
      check(card_clock_out, 1'b0, "card clock in sleep");
      card_power_request_n = 1'b0;
      tick(50);
      check(converter_on, 1'b0, "no start in sleep");
      mode_in = 1'b1;
      tick(59000);
      check(converter_on, 1'b0, "wake delay");
      wait_conv(1'b1, 2000);
      $display("test sleep done");
      tick(300);
      overcurrent_in = 1'b1;
      tick(5);
      overcurrent_in = 1'b0;
      check(fault_irq_oe, 1'b1, "fault irq");
      wait_conv(1'b0, 1000);
      tick(5);
      check(fault_irq_oe, 1'b1, "fault irq held");
      card_power_request_n = 1'b1;
      tick(10);
      check(fault_irq_oe, 1'b0, "fault irq released");
      supply_below_lower = 1'b1;
      tick(6);
      check(alarm_out, 1'b1, "alarm on drop");
      $display("test fault done");
      results;
   end
endmodule : smart_card_interface_control_tb
`default_nettype wire
